// >>> src/tpw_pkg.sv
// tpw_pkg: register map, field layout and codes of the 8-bit pwm timer.
// assumes a 32-bit classic wishbone bus; registers sit in the low byte.
package tpw_pkg;

    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    localparam int CNT_W = 8;
    localparam int PRE_W = 10;

    // byte addresses, one aligned word each
    localparam logic [ADR_W-1:0] OFS_CTRL_A = 8'h00;
    localparam logic [ADR_W-1:0] OFS_CTRL_B = 8'h04;
    localparam logic [ADR_W-1:0] OFS_COUNT = 8'h08;
    localparam logic [ADR_W-1:0] OFS_CMP_A = 8'h0C;
    localparam logic [ADR_W-1:0] OFS_CMP_B = 8'h10;
    localparam logic [ADR_W-1:0] OFS_FLAGS = 8'h14;
    localparam logic [ADR_W-1:0] OFS_PORT = 8'h18;

    // control A: action A [7:6], action B [5:4], low mode bits [1:0]
    localparam int ACT_A_LSB = 6;
    localparam int ACT_B_LSB = 4;
    localparam int WGM_LSB = 0;
    // control B: mode extension bit 3, prescale select [2:0]
    localparam int EXT_BIT = 3;
    localparam int PSEL_LSB = 0;
    // flags: overflow 0, compare a 1, compare b 2
    localparam int FLG_OVF = 0;
    localparam int FLG_CMPA = 1;
    localparam int FLG_CMPB = 2;
    // port: direction a 0, direction b 1, port level a 2, port level b 3
    localparam int DIR_A = 0;
    localparam int DIR_B = 1;
    localparam int LVL_A = 2;
    localparam int LVL_B = 3;

    localparam logic [2:0] MODE_FAST_FF = 3'h3;
    localparam logic [2:0] MODE_FAST_CA = 3'h7;
    localparam logic [2:0] MODE_PC_FF = 3'h1;
    localparam logic [2:0] MODE_PC_CA = 3'h5;

    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_NONINV = 2'h2;
    localparam logic [1:0] ACT_INV = 2'h3;

    // prescale select codes: stopped, 1, 8, 64, 256, 1024
    localparam logic [2:0] PS_STOP = 3'h0;
    localparam logic [2:0] PS_1 = 3'h1;
    localparam logic [2:0] PS_8 = 3'h2;
    localparam logic [2:0] PS_64 = 3'h3;
    localparam logic [2:0] PS_256 = 3'h4;
    localparam logic [2:0] PS_1024 = 3'h5;

    localparam logic [CNT_W-1:0] CNT_BOTTOM = 8'h00;
    localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] REG_RESET = 8'h00;

    typedef enum logic [1:0] {
        TPW_NORMAL,
        TPW_FAST,
        TPW_PHASE
    } tpw_kind_e;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [ADR_W-1:0] adr;
        logic [DAT_W-1:0] dat;
    } tpw_wb_req_s;

    typedef struct packed {
        logic ack;
        logic [DAT_W-1:0] dat;
    } tpw_wb_rsp_s;

    typedef struct packed {
        logic val;
        logic oe;
    } tpw_pin_s;

endpackage

// >>> src/tpw_timer.sv
// tpw_timer: 8-bit timer with fast and phase correct pwm on two outputs.
// assumes one clock, wishbone classic master on the same clock, and pins
// that are output only (enable high while the pin is driven).
//
// Behaviour
// - modes 3 and 7 count up, restart bottom
// - fast top is 0xFF or compare A
// - fast: clear on match, set bottom; inverted opposite
// - clear at tick after top; output changes then
// - fast overflow flag set at tick after top, as counter wraps to bottom
// - fast toggle on A only with extension bit
// - fast toggle uses buffered compare value
// - fast extremes: spike at zero, constant at max
// - prescale divides clock by 1,8,64,256,1024
// - modes 1 and 5 count up then down
// - phase top is 0xFF or compare A
// - phase: clear on up match, set down
// - counter holds top for one tick
// - phase overflow flag set at bottom
// - phase modes 2,3 pwm; toggle A only
// - phase period 510 ticks at top 0xFF (twice top otherwise), prescaled clock
// - phase extremes give constant low or high
// - leaving max switches output at bottom
// - missed up match still switches at bottom
// - synchronous apart from the asynchronous reset, tick is clock enable only
// - pin driven only when direction is output
// - action zero leaves pin to port use
`timescale 1ns/1ps

module tpw_timer
    import tpw_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // wishbone classic slave
    input wire tpw_pkg::tpw_wb_req_s WB_REQ,
    output tpw_pkg::tpw_wb_rsp_s WB_RSP,
    // compare output pins
    output tpw_pkg::tpw_pin_s PIN_A,
    output tpw_pkg::tpw_pin_s PIN_B,
    // overflow level for observers
    output logic OVF_FLAG
);
    import tpw_pkg::*;

    typedef struct packed {
        logic [7:0] ctrl_a;
        logic [7:0] ctrl_b;
        logic [7:0] port;
        logic [CNT_W-1:0] cnt;
        logic down;
        logic blk;
        logic saw_up_a;
        logic saw_up_b;
        logic [CNT_W-1:0] cmpa_sw;
        logic [CNT_W-1:0] cmpb_sw;
        logic [CNT_W-1:0] cmpa;
        logic [CNT_W-1:0] cmpb;
        logic oc_a;
        logic oc_b;
        logic [2:0] flags;
        logic [PRE_W-1:0] pre;
        tpw_wb_rsp_s rsp;
        tpw_pin_s pin_a;
        tpw_pin_s pin_b;
    } tpw_state_s;

    tpw_state_s s_q;
    tpw_state_s s_d;

    // one-clock enable from the free-running prescaler
    function automatic logic tick_of(input logic [2:0] psel,
                                     input logic [PRE_W-1:0] pre);
        case (psel)
            PS_1: tick_of = 1'b1;
            PS_8: tick_of = &pre[2:0];
            PS_64: tick_of = &pre[5:0];
            PS_256: tick_of = &pre[7:0];
            PS_1024: tick_of = &pre[9:0];
            default: tick_of = 1'b0;
        endcase
    endfunction

    // level that an up-counting match produces for the given action
    function automatic logic up_level(input logic [1:0] act);
        up_level = (act == ACT_INV);
    endfunction

    // pin driven only when direction is output; action zero shows the port level
    function automatic tpw_pin_s pin_of(input logic [1:0] act, input logic oc,
                                        input logic dir, input logic lvl);
        pin_of.oe = dir;
        pin_of.val = (act == ACT_NONE) ? lvl : oc;
    endfunction

    logic [2:0] mode;
    tpw_kind_e kind;
    logic [CNT_W-1:0] top;
    logic tick;
    logic [1:0] act_a;
    logic [1:0] act_b;
    logic ext;
    logic wb_go;
    logic [7:0] wr_byte;
    logic [7:0] rd_byte;

    always_comb begin
        mode = {s_q.ctrl_b[EXT_BIT], s_q.ctrl_a[WGM_LSB +: 2]};
        ext = s_q.ctrl_b[EXT_BIT];
        act_a = s_q.ctrl_a[ACT_A_LSB +: 2];
        act_b = s_q.ctrl_a[ACT_B_LSB +: 2];
        case (mode)
            MODE_FAST_FF, MODE_FAST_CA: kind = TPW_FAST;
            MODE_PC_FF, MODE_PC_CA: kind = TPW_PHASE;
            default: kind = TPW_NORMAL;
        endcase
        top = (mode == MODE_FAST_CA || mode == MODE_PC_CA) ? s_q.cmpa : CNT_MAX;
        tick = tick_of(s_q.ctrl_b[PSEL_LSB +: 3], s_q.pre);
        wb_go = WB_REQ.cyc && WB_REQ.stb && !s_q.rsp.ack;
        wr_byte = WB_REQ.dat[7:0];
        case (WB_REQ.adr)
            OFS_CTRL_A: rd_byte = s_q.ctrl_a & 8'hF3;
            OFS_CTRL_B: rd_byte = s_q.ctrl_b & 8'h0F;
            OFS_COUNT: rd_byte = s_q.cnt;
            OFS_CMP_A: rd_byte = s_q.cmpa_sw;
            OFS_CMP_B: rd_byte = s_q.cmpb_sw;
            OFS_FLAGS: rd_byte = {5'h00, s_q.flags};
            OFS_PORT: rd_byte = s_q.port & 8'h0F;
            default: rd_byte = 8'h00;
        endcase
    end

    // per-channel compare action; a is the only channel allowed to toggle
    logic match_a;
    logic match_b;
    logic at_top;
    logic at_bottom;

    always_comb begin
        at_top = (s_q.cnt == top);
        at_bottom = (s_q.cnt == CNT_BOTTOM);
        // a counter write suppresses the next tick's matches
        match_a = tick && !s_q.blk && (s_q.cnt == s_q.cmpa);
        match_b = tick && !s_q.blk && (s_q.cnt == s_q.cmpb);
    end

    always_comb begin
        s_d = s_q;
        s_d.pre = s_q.pre + 1'b1;
        if (tick) begin
            s_d.blk = 1'b0;
        end

        // counting
        if (tick) begin
            case (kind)
                TPW_FAST: begin
                    if (at_top) begin
                        s_d.cnt = CNT_BOTTOM;
                        s_d.flags[FLG_OVF] = 1'b1;
                        s_d.cmpa = s_q.cmpa_sw;
                        s_d.cmpb = s_q.cmpb_sw;
                    end else begin
                        s_d.cnt = s_q.cnt + 1'b1;
                    end
                end
                TPW_PHASE: begin
                    if (!s_q.down) begin
                        if (at_top) begin
                            // top shown for this one tick only
                            s_d.down = 1'b1;
                            s_d.cnt = s_q.cnt - 1'b1;
                            s_d.cmpa = s_q.cmpa_sw;
                            s_d.cmpb = s_q.cmpb_sw;
                        end else begin
                            s_d.cnt = s_q.cnt + 1'b1;
                        end
                    end else if (at_bottom) begin
                        s_d.down = 1'b0;
                        s_d.cnt = s_q.cnt + 1'b1;
                        s_d.flags[FLG_OVF] = 1'b1;
                    end else begin
                        s_d.cnt = s_q.cnt - 1'b1;
                    end
                end
                default: begin
                    // other modes: plain up counter, compares load at once
                    s_d.cnt = s_q.cnt + 1'b1;
                    s_d.cmpa = s_q.cmpa_sw;
                    s_d.cmpb = s_q.cmpb_sw;
                    if (s_q.cnt == CNT_MAX) begin
                        s_d.flags[FLG_OVF] = 1'b1;
                    end
                end
            endcase
        end

        if (match_a) begin
            s_d.flags[FLG_CMPA] = 1'b1;
        end
        if (match_b) begin
            s_d.flags[FLG_CMPB] = 1'b1;
        end

        // waveform, channel a
        if (tick && kind == TPW_FAST) begin
            if (act_a == ACT_TOGGLE && ext) begin
                if (match_a) begin
                    s_d.oc_a = !s_q.oc_a;
                end
            end else if (act_a[1]) begin
                if (at_top) begin
                    // bottom level wins; a match at top is ignored
                    s_d.oc_a = !up_level(act_a);
                end else if (match_a) begin
                    s_d.oc_a = up_level(act_a);
                end
            end
        end
        if (tick && kind == TPW_PHASE) begin
            if (act_a == ACT_TOGGLE && ext) begin
                if (match_a) begin
                    s_d.oc_a = !s_q.oc_a;
                end
            end else if (act_a[1]) begin
                if (s_q.cmpa == top) begin
                    if (at_top && !s_q.down) begin
                        s_d.oc_a = !up_level(act_a);
                    end
                end else if (match_a && (!s_q.down || at_bottom)) begin
                    s_d.oc_a = up_level(act_a);
                    s_d.saw_up_a = 1'b1;
                end else if (match_a) begin
                    s_d.oc_a = !up_level(act_a);
                end else if (s_q.down && at_bottom && !s_q.saw_up_a) begin
                    // keeps the pulse centred when an up match was skipped
                    s_d.oc_a = up_level(act_a);
                end
                if (s_q.down && at_bottom && s_q.cmpa != CNT_BOTTOM) begin
                    s_d.saw_up_a = 1'b0;
                end
            end
        end

        // waveform, channel b: no toggle option
        if (tick && kind == TPW_FAST && act_b[1]) begin
            if (at_top) begin
                s_d.oc_b = !up_level(act_b);
            end else if (match_b) begin
                s_d.oc_b = up_level(act_b);
            end
        end
        if (tick && kind == TPW_PHASE && act_b[1]) begin
            if (s_q.cmpb == top) begin
                if (at_top && !s_q.down) begin
                    s_d.oc_b = !up_level(act_b);
                end
            end else if (match_b && (!s_q.down || at_bottom)) begin
                s_d.oc_b = up_level(act_b);
                s_d.saw_up_b = 1'b1;
            end else if (match_b) begin
                s_d.oc_b = !up_level(act_b);
            end else if (s_q.down && at_bottom && !s_q.saw_up_b) begin
                s_d.oc_b = up_level(act_b);
            end
            if (s_q.down && at_bottom && s_q.cmpb != CNT_BOTTOM) begin
                s_d.saw_up_b = 1'b0;
            end
        end

        // bus: answer one cycle after the request is seen
        s_d.rsp.ack = wb_go;
        s_d.rsp.dat = wb_go ? {24'h000000, rd_byte} : '0;
        if (wb_go && WB_REQ.we && WB_REQ.sel[0]) begin
            case (WB_REQ.adr)
                OFS_CTRL_A: s_d.ctrl_a = wr_byte & 8'hF3;
                OFS_CTRL_B: s_d.ctrl_b = wr_byte & 8'h0F;
                OFS_COUNT: begin
                    s_d.cnt = wr_byte;
                    s_d.blk = 1'b1;
                end
                OFS_CMP_A: s_d.cmpa_sw = wr_byte;
                OFS_CMP_B: s_d.cmpb_sw = wr_byte;
                // write one to clear; a same-cycle set wins only if the flag was clear
                OFS_FLAGS: s_d.flags = (s_d.flags & ~wr_byte[2:0]) | (s_d.flags & ~s_q.flags);
                OFS_PORT: s_d.port = wr_byte & 8'h0F;
                default: ;
            endcase
        end

        s_d.pin_a = pin_of(act_a, s_d.oc_a, s_d.port[DIR_A], s_d.port[LVL_A]);
        s_d.pin_b = pin_of(act_b, s_d.oc_b, s_d.port[DIR_B], s_d.port[LVL_B]);
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign WB_RSP = s_q.rsp;
    assign PIN_A = s_q.pin_a;
    assign PIN_B = s_q.pin_b;
    assign OVF_FLAG = s_q.flags[FLG_OVF];

endmodule

// >>> test/tpw_load.sv
// tpw_load: load on one compare pin, counts clocks it is driven high.
// assumes the bench clears it before each measuring window.
`timescale 1ns/1ps

module tpw_load
    import tpw_pkg::*;
(
    input wire logic clk,
    input wire logic clr,
    input wire tpw_pkg::tpw_pin_s pin,
    output logic [15:0] hi_cnt
);
    // an undriven pin never counts as high
    always_ff @(posedge clk) begin
        if (clr) begin
            hi_cnt <= 16'h0;
        end else if (pin.oe && pin.val) begin
            hi_cnt <= hi_cnt + 16'h1;
        end
    end
endmodule

// >>> test/tpw_timer_assertions.sv
// tpw_timer_checker: bus and pin relations on the timer's top ports.
// assumes tpw_pkg and the tpw_timer top; attached by the bind below.
`timescale 1ns/1ps

module tpw_timer_checker
    import tpw_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // register bus
    input wire tpw_pkg::tpw_wb_req_s WB_REQ,
    input wire tpw_pkg::tpw_wb_rsp_s WB_RSP,
    // pins and flag
    input wire tpw_pkg::tpw_pin_s PIN_A,
    input wire tpw_pkg::tpw_pin_s PIN_B,
    input wire logic OVF_FLAG
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);

    property p_ack_take;
        WB_REQ.cyc && WB_REQ.stb && !WB_RSP.ack |=> WB_RSP.ack;
    endproperty
    a_ack_take: assert property (p_ack_take) else $error("ack missing");
    property p_ack_pulse;
        WB_RSP.ack |=> !WB_RSP.ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_ack_cause;
        WB_RSP.ack |-> $past(WB_REQ.cyc && WB_REQ.stb);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
    property p_dat_idle;
        !WB_RSP.ack |-> WB_RSP.dat == 32'h0;
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("data without ack");
    property p_dat_byte;
        WB_RSP.ack |-> WB_RSP.dat[31:8] == 24'h0;
    endproperty
    a_dat_byte: assert property (p_dat_byte) else $error("upper data set");
    property p_oe_a;
        $changed(PIN_A.oe) |-> WB_RSP.ack || $past(WB_RSP.ack);
    endproperty
    a_oe_a: assert property (p_oe_a) else $error("pin a enable moved alone");
    property p_oe_b;
        $changed(PIN_B.oe) |-> WB_RSP.ack || $past(WB_RSP.ack);
    endproperty
    a_oe_b: assert property (p_oe_b) else $error("pin b enable moved alone");
    property p_ovf_clear;
        $fell(OVF_FLAG) |-> WB_RSP.ack || $past(WB_RSP.ack);
    endproperty
    a_ovf_clear: assert property (p_ovf_clear) else $error("flag fell alone");

    c_write: cover property (WB_RSP.ack && WB_REQ.we);
    c_ovf: cover property ($rose(OVF_FLAG));
    c_pin: cover property ($rose(PIN_A.val) && PIN_A.oe);
endmodule

bind tpw_timer tpw_timer_checker i_tpw_timer_checker (.CLK(CLK), .SYS_RST(SYS_RST),
    .WB_REQ(WB_REQ), .WB_RSP(WB_RSP), .PIN_A(PIN_A), .PIN_B(PIN_B), .OVF_FLAG(OVF_FLAG));

// >>> test/tpw_timer_tb.sv
// tpw_timer_tb: bus, pwm duty, overflow and pin checks of tpw_timer.
// assumes tpw_pkg, the checker bind and the tpw_load model.
`timescale 1ns/1ps

module tpw_timer_tb
    import tpw_pkg::*;
;
    logic CLK = 1'b0;
    logic SYS_RST = 1'b1;
    tpw_wb_req_s req = '0;
    tpw_wb_rsp_s rsp;
    tpw_pin_s pin_a;
    tpw_pin_s pin_b;
    logic ovf;
    logic load_clr = 1'b1;
    logic [15:0] hi_a;
    logic [15:0] hi_b;
    logic [7:0] rd;
    logic [7:0] a;
    logic [7:0] v;
    int bad_count = 0;
    int samples_checked = 0;

    always #5 CLK = ~CLK;

    tpw_timer i_tpw_timer (.CLK(CLK), .SYS_RST(SYS_RST), .WB_REQ(req), .WB_RSP(rsp),
        .PIN_A(pin_a), .PIN_B(pin_b), .OVF_FLAG(ovf));
    tpw_load i_tpw_load_a (.clk(CLK), .clr(load_clr), .pin(pin_a), .hi_cnt(hi_a));
    tpw_load i_tpw_load_b (.clk(CLK), .clr(load_clr), .pin(pin_b), .hi_cnt(hi_b));

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] adr, input logic [7:0] d);
        int n;
        n = 0;
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hF, adr: adr, dat: {24'h0, d}};
        do begin
            @(posedge CLK);
            n++;
        end while (rsp.ack !== 1'b1 && n < 64);
        chk("bus_ack", 32'h1, {31'h0, rsp.ack});
        rd = rsp.dat[7:0];
        req.cyc <= 1'b0;
        req.stb <= 1'b0;
        @(posedge CLK);
    endtask

    task automatic measure(input int n);
        load_clr <= 1'b1;
        @(posedge CLK);
        load_clr <= 1'b0;
        repeat (n + 1) @(posedge CLK);
    endtask

    // high ticks per period; inverted output is the rest of the period
    function automatic int exp_hi(input logic fast, input int val, input int top,
                                  input logic inv);
        int per;
        int h;
        per = fast ? top + 1 : 2 * top;
        h = fast ? val + 1 : 2 * val;
        return inv ? per - h : h;
    endfunction

    task automatic run_case(input logic [2:0] m, input logic [2:0] ps, input int div,
                            input logic inv, input logic [7:0] ca, input logic [7:0] cb);
        int top;
        int per;
        top = m[2] ? int'(ca) : 255;
        per = (m[1] ? top + 1 : 2 * top) * div;
        wb(1'b1, OFS_CMP_A, ca);
        wb(1'b1, OFS_CMP_B, cb);
        wb(1'b1, OFS_CTRL_B, {4'h0, m[2], ps});
        wb(1'b1, OFS_CTRL_A, {inv ? 4'hF : 4'hA, 2'h0, m[1:0]});
        wb(1'b1, OFS_PORT, 8'h03);
        // a counter left above a new top must wrap first
        repeat (3 * per + 600) @(posedge CLK);
        measure(2 * per);
        chk("high_a", 32'(2 * div * exp_hi(m[1], int'(ca), top, inv)), {16'h0, hi_a});
        chk("high_b", 32'(2 * div * exp_hi(m[1], int'(cb), top, inv)), {16'h0, hi_b});
        wb(1'b1, OFS_FLAGS, 8'h07);
        repeat (per + 4) @(posedge CLK);
        chk("overflow", 32'h1, {31'h0, ovf});
    endtask

    initial begin
        repeat (100000) @(posedge CLK);
        bad_count++;
        report_and_stop();
    end

    initial begin
        void'($urandom(32'hABF1));
        repeat (8) @(posedge CLK);
        SYS_RST <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            wb(1'b0, 8'(i * 4), 8'h00);
            chk("reset_read", 32'h0, {24'h0, rd});
        end
        repeat (3) begin
            v = 8'($urandom_range(255, 0));
            wb(1'b1, OFS_CMP_B, v);
            wb(1'b0, OFS_CMP_B, 8'h00);
            chk("cmp_b_read", {24'h0, v}, {24'h0, rd});
        end
        a = 8'($urandom_range(254, 2));
        run_case(MODE_FAST_FF, PS_1, 1, 1'b0, a, 8'($urandom_range(255, 0)));
        run_case(MODE_FAST_FF, PS_1, 1, 1'b1, 8'h00, 8'hFF);
        run_case(MODE_FAST_FF, PS_8, 8, 1'b0, a, 8'($urandom_range(255, 0)));
        run_case(MODE_FAST_CA, PS_1, 1, 1'b0, a, 8'($urandom_range(a, 0)));
        run_case(MODE_PC_FF, PS_1, 1, 1'b0, a, 8'($urandom_range(255, 0)));
        run_case(MODE_PC_FF, PS_1, 1, 1'b1, 8'hFF, 8'h00);
        run_case(MODE_PC_CA, PS_1, 1, 1'b1, a, 8'($urandom_range(a, 0)));
        // compare zero with top zero: toggles every clock
        wb(1'b1, OFS_CMP_A, 8'h00);
        wb(1'b1, OFS_CTRL_B, 8'h09);
        wb(1'b1, OFS_CTRL_A, 8'h53);
        repeat (600) @(posedge CLK);
        measure(256);
        chk("toggle_a", 32'h80, {16'h0, hi_a});
        chk("steady_b", 32'h0, {24'h0, hi_b[7:0]});
        wb(1'b1, OFS_CTRL_A, 8'h03);
        wb(1'b1, OFS_PORT, 8'h04);
        repeat (2) @(posedge CLK);
        chk("oe_a", 32'h0, {31'h0, pin_a.oe});
        wb(1'b1, OFS_PORT, 8'h07);
        repeat (2) @(posedge CLK);
        chk("port_a", 32'h1, {31'h0, pin_a.val});
        chk("port_b", 32'h0, {31'h0, pin_b.val});
        report_and_stop();
    end
endmodule
